// [design/sis_group_pick.sv]
// least-recently-issued picker for one group of four strands
// assumes grant only follows a valid winner in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sis_group_pick (
   // clock, reset and enable
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // link to the selector
   sis_pick_if.picker pick
);
   // order_r[0] issued least recently, order_r[3] most recently
   logic [sis_pkg::GIDX_W-1:0] order_r [sis_pkg::GROUP_SIZE];
   logic [sis_pkg::GIDX_W-1:0] win_pos;

   // scan from most recent down so the oldest eligible strand wins
   always_comb begin
      pick.win_vld = 1'b0;
      pick.win_idx = order_r[0];
      win_pos = '0;
      for (int k = sis_pkg::GROUP_SIZE - 1; k >= 0; k--) begin
         if (pick.elig[order_r[k]]) begin
            pick.win_vld = 1'b1;
            pick.win_idx = order_r[k];
            win_pos = k[sis_pkg::GIDX_W-1:0];
         end
      end
   end

   // winner moves to the back; no grant leaves the order alone
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         for (int k = 0; k < sis_pkg::GROUP_SIZE; k++) begin
            order_r[k] <= k[sis_pkg::GIDX_W-1:0];
         end
      end else if (i_ce && pick.grant) begin
         for (int k = 0; k < sis_pkg::GROUP_SIZE - 1; k++) begin
            if (k >= int'(win_pos)) begin
               order_r[k] <= order_r[k+1];
            end
         end
         order_r[sis_pkg::GROUP_SIZE-1] <= order_r[win_pos];
      end
   end

   a_lri_winner_back: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && pick.grant) |=> (order_r[3] == $past(pick.win_idx)))
      else $error("granted strand not moved to most recent");
   a_idle_order_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !pick.grant |=> ((order_r[0] == $past(order_r[0]))
         && (order_r[1] == $past(order_r[1])) && (order_r[2] == $past(order_r[2]))
         && (order_r[3] == $past(order_r[3]))))
      else $error("order changed in an idle cycle");
   a_winner_eligible: assert property (@(posedge i_clk) disable iff (!i_rstn)
      pick.win_vld |-> pick.elig[pick.win_idx])
      else $error("winner is not an eligible strand");
endmodule // sis_group_pick
`default_nettype wire

// [design/sis_issue_select.sv]
// strand issue selector for one core: eight strands, two groups, two issues
// assumes fetch holds an instruction until taken, pipes raise ready to drain
`timescale 1ns/10ps
`default_nettype none
module sis_issue_select (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // instruction supply, one slot per strand
   input wire logic [sis_pkg::NUM_STRANDS-1:0] i_inst_vld,
   input wire logic [sis_pkg::NUM_STRANDS-1:0][sis_pkg::INST_W-1:0] i_inst,
   input wire logic [sis_pkg::NUM_STRANDS-1:0][sis_pkg::CLS_W-1:0] i_inst_cls,
   output logic [sis_pkg::NUM_STRANDS-1:0] o_inst_take,
   // long-latency events
   input wire logic [sis_pkg::NUM_STRANDS-1:0] i_lle_start,
   input wire logic [sis_pkg::NUM_STRANDS-1:0] i_lle_done,
   output logic [sis_pkg::NUM_STRANDS-1:0] o_strand_avail,
   // integer pipes, one per group
   input wire logic [sis_pkg::NUM_GROUPS-1:0] i_int_rdy,
   output logic [sis_pkg::NUM_GROUPS-1:0] o_int_vld,
   output logic [sis_pkg::NUM_GROUPS-1:0][sis_pkg::SID_W-1:0] o_int_sid,
   output logic [sis_pkg::NUM_GROUPS-1:0][sis_pkg::INST_W-1:0] o_int_inst,
   // shared floating-point pipe
   input wire logic i_fp_rdy,
   output logic o_fp_vld,
   output logic [sis_pkg::SID_W-1:0] o_fp_sid,
   output logic [sis_pkg::INST_W-1:0] o_fp_inst,
   // shared memory pipe
   input wire logic i_mem_rdy,
   output logic o_mem_vld,
   output logic [sis_pkg::SID_W-1:0] o_mem_sid,
   output logic [sis_pkg::INST_W-1:0] o_mem_inst
);
   localparam int unsigned NS = sis_pkg::NUM_STRANDS;
   localparam int unsigned NG = sis_pkg::NUM_GROUPS;

   // a strand may only compete if its target pipe can take it now
   function automatic logic pipe_free(input logic [sis_pkg::CLS_W-1:0] cls,
         input logic int_f, input logic fp_f, input logic mem_f);
      case (cls)
         sis_pkg::SIS_CLS_INT: pipe_free = int_f;
         sis_pkg::SIS_CLS_FP: pipe_free = fp_f;
         sis_pkg::SIS_CLS_MEM: pipe_free = mem_f;
         default: pipe_free = 1'b0;
      endcase
   endfunction

   logic [NS-1:0] unavail_r;
   logic turn_r;
   logic [NG-1:0] int_vld_r;
   logic [NG-1:0][sis_pkg::SID_W-1:0] int_sid_r;
   logic [NG-1:0][sis_pkg::INST_W-1:0] int_inst_r;
   logic fp_vld_r, mem_vld_r;
   logic [sis_pkg::SID_W-1:0] fp_sid_r, mem_sid_r;
   logic [sis_pkg::INST_W-1:0] fp_inst_r, mem_inst_r;
   logic [NG-1:0] int_free;
   logic fp_free, mem_free;
   logic [NS-1:0] elig;
   logic [NG-1:0] win_vld, grant;
   logic [NG-1:0][sis_pkg::SID_W-1:0] win_sid;
   logic [NG-1:0][sis_pkg::CLS_W-1:0] win_cls;
   logic [NG-1:0][sis_pkg::INST_W-1:0] win_inst;
   logic conflict;
   logic fp_go, mem_go;
   logic [sis_pkg::SID_W-1:0] fp_sid_nxt, mem_sid_nxt;
   logic [sis_pkg::INST_W-1:0] fp_inst_nxt, mem_inst_nxt;

   // a held pipe register frees up in the same cycle it drains
   assign fp_free = !fp_vld_r || i_fp_rdy;
   assign mem_free = !mem_vld_r || i_mem_rdy;

   // eligibility: waiting on an event, even one starting now, excludes the strand
   always_comb begin
      elig = '0;
      for (int s = 0; s < NS; s++) begin
         elig[s] = i_inst_vld[s] && !unavail_r[s] && !i_lle_start[s]
            && pipe_free(i_inst_cls[s], int_free[s / sis_pkg::GROUP_SIZE], fp_free, mem_free);
      end
   end

   // one picker per group; strand id top bit is the group number
   for (genvar g = 0; g < NG; g++) begin : g_grp
      sis_pick_if pick_if ();
      assign int_free[g] = !int_vld_r[g] || i_int_rdy[g];
      assign pick_if.elig = elig[g*sis_pkg::GROUP_SIZE +: sis_pkg::GROUP_SIZE];
      assign pick_if.grant = grant[g];
      assign win_vld[g] = pick_if.win_vld;
      assign win_sid[g] = {1'(g), pick_if.win_idx};
      assign win_cls[g] = i_inst_cls[win_sid[g]];
      assign win_inst[g] = i_inst[win_sid[g]];
      // nothing issues from a group that lost or froze
      assign grant[g] = i_ce && win_vld[g] && !(conflict && (turn_r != 1'(g)));
      sis_group_pick u_pick (
         .i_clk(i_clk),
         .i_rstn(i_rstn),
         .i_ce(i_ce),
         .pick(pick_if.picker)
      );
   end

   // two winners wanting the same shared pipe: only one goes, turns alternate
   assign conflict = win_vld[0] && win_vld[1] && (win_cls[0] == win_cls[1])
      && (win_cls[0] != sis_pkg::SIS_CLS_INT);

   // take strobes and routing of winners to the shared pipes
   always_comb begin
      o_inst_take = '0;
      fp_go = 1'b0;
      mem_go = 1'b0;
      fp_sid_nxt = '0;
      mem_sid_nxt = '0;
      fp_inst_nxt = '0;
      mem_inst_nxt = '0;
      for (int g = 0; g < NG; g++) begin
         if (grant[g]) begin
            o_inst_take[win_sid[g]] = 1'b1;
            if (win_cls[g] == sis_pkg::SIS_CLS_FP) begin
               fp_go = 1'b1;
               fp_sid_nxt = win_sid[g];
               fp_inst_nxt = win_inst[g];
            end
            if (win_cls[g] == sis_pkg::SIS_CLS_MEM) begin
               mem_go = 1'b1;
               mem_sid_nxt = win_sid[g];
               mem_inst_nxt = win_inst[g];
            end
         end
      end
   end

   // unavailable flags: a new event wins over a resolve in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         unavail_r <= {NS{sis_pkg::RST_UNAVAIL}};
      end else if (i_ce) begin
         unavail_r <= (unavail_r & ~i_lle_done) | i_lle_start;
      end
   end

   // shared-pipe tie breaker
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         turn_r <= sis_pkg::RST_TURN;
      end else if (i_ce && conflict) begin
         turn_r <= !turn_r;
      end
   end

   // integer pipe registers, group g feeds only pipe g
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         int_vld_r <= {NG{sis_pkg::RST_VLD}};
         int_sid_r <= '0;
         int_inst_r <= '0;
      end else if (i_ce) begin
         for (int g = 0; g < NG; g++) begin
            if (grant[g] && (win_cls[g] == sis_pkg::SIS_CLS_INT)) begin
               int_vld_r[g] <= 1'b1;
               int_sid_r[g] <= win_sid[g];
               int_inst_r[g] <= win_inst[g];
            end else if (i_int_rdy[g]) begin
               int_vld_r[g] <= 1'b0;
            end
         end
      end
   end

   // shared floating-point and memory pipe registers
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         fp_vld_r <= sis_pkg::RST_VLD;
         mem_vld_r <= sis_pkg::RST_VLD;
         fp_sid_r <= '0;
         mem_sid_r <= '0;
         fp_inst_r <= '0;
         mem_inst_r <= '0;
      end else if (i_ce) begin
         if (fp_go) begin
            fp_vld_r <= 1'b1;
            fp_sid_r <= fp_sid_nxt;
            fp_inst_r <= fp_inst_nxt;
         end else if (i_fp_rdy) begin
            fp_vld_r <= 1'b0;
         end
         if (mem_go) begin
            mem_vld_r <= 1'b1;
            mem_sid_r <= mem_sid_nxt;
            mem_inst_r <= mem_inst_nxt;
         end else if (i_mem_rdy) begin
            mem_vld_r <= 1'b0;
         end
      end
   end

   // outputs straight from the registers
   assign o_strand_avail = ~unavail_r;
   assign o_int_vld = int_vld_r;
   assign o_int_sid = int_sid_r;
   assign o_int_inst = int_inst_r;
   assign o_fp_vld = fp_vld_r;
   assign o_fp_sid = fp_sid_r;
   assign o_fp_inst = fp_inst_r;
   assign o_mem_vld = mem_vld_r;
   assign o_mem_sid = mem_sid_r;
   assign o_mem_inst = mem_inst_r;

   a_group_int_route: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (!o_int_vld[0] || !o_int_sid[0][2]) && (!o_int_vld[1] || o_int_sid[1][2]))
      else $error("integer pipe holds a strand of the other group");
   a_issue_two_max: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ($countones(o_inst_take) <= sis_pkg::MAX_ISSUE) && $onehot0(o_inst_take[3:0])
         && $onehot0(o_inst_take[7:4]))
      else $error("more than two strands issued");
   a_pair_legal: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (grant[0] && grant[1]) |-> ((win_cls[0] == sis_pkg::SIS_CLS_INT)
         || (win_cls[1] == sis_pkg::SIS_CLS_INT) || (win_cls[0] != win_cls[1])))
      else $error("illegal issue pairing");
   a_blocked_no_issue: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_inst_take & (unavail_r | i_lle_start)) == '0)
      else $error("unavailable strand issued");
   a_event_marks: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && (i_lle_start != '0)) |=> ((o_strand_avail & $past(i_lle_start)) == '0))
      else $error("event did not mark strand unavailable");
   a_others_continue: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && (elig[3:0] != '0) && !conflict) |-> (o_inst_take[3:0] != '0))
      else $error("eligible strand not issued");
   a_fp_any_strand: assert property (@(posedge i_clk) disable iff (!i_rstn)
      fp_go |=> (o_fp_vld && (o_fp_sid == $past(fp_sid_nxt))))
      else $error("floating-point issue lost");
   a_own_state: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (grant[1] && (win_cls[1] == sis_pkg::SIS_CLS_INT))
         |=> (o_int_inst[1] == $past(win_inst[1])) && (o_int_sid[1] == $past(win_sid[1])))
      else $error("issued word not from its own strand");
   a_idle_group: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (elig[7:4] == '0) |-> (o_inst_take[7:4] == '0) && !grant[1])
      else $error("idle group issued");
endmodule // sis_issue_select
`default_nettype wire

// [design/sis_pick_if.sv]
// carrier between the selector top and one group picker
// assumes both ends sit on the same core clock
`timescale 1ns/10ps
`default_nettype none
interface sis_pick_if;
   logic [sis_pkg::GROUP_SIZE-1:0] elig;
   logic grant;
   logic win_vld;
   logic [sis_pkg::GIDX_W-1:0] win_idx;
   modport picker (input elig, input grant, output win_vld, output win_idx);
   modport ctrl (output elig, output grant, input win_vld, input win_idx);
endinterface
`default_nettype wire

// [design/sis_pkg.sv]
// constants and types for the strand issue selector
// assumes one core clock domain; widths fixed, nothing is imported by users
package sis_pkg;
   // strand organisation
   localparam int unsigned NUM_STRANDS = 8;
   localparam int unsigned NUM_GROUPS = 2;
   localparam int unsigned GROUP_SIZE = 4;
   localparam int unsigned MAX_ISSUE = 2;
   localparam int unsigned REG_WINDOWS = 8;
   // field widths
   localparam int unsigned INST_W = 32;
   localparam int unsigned SID_W = 3;
   localparam int unsigned GIDX_W = 2;
   localparam int unsigned CLS_W = 2;
   // values after reset
   localparam logic RST_UNAVAIL = 1'b0;
   localparam logic RST_TURN = 1'b0;
   localparam logic RST_VLD = 1'b0;

   // instruction class, tells which pipeline takes it
   typedef enum logic [1:0] {
      SIS_CLS_INT = 2'b00,
      SIS_CLS_FP = 2'b01,
      SIS_CLS_MEM = 2'b10,
      SIS_CLS_RSV = 2'b11
   } sis_class_type;
endpackage

// [tb/sis_pipe_sink.sv]
// model of the execution pipes that drain the issue slots
// assumes the bench picks which pipe stalls; ready is sampled at the rising edge
`timescale 1ns/10ps
`default_nettype none
module sis_pipe_sink (
   // stall request per pipe: int0, int1, fp, mem
   input wire logic [3:0] i_stall,
   // drain strobes towards the selector
   output logic [1:0] o_int_rdy,
   output logic o_fp_rdy,
   output logic o_mem_rdy
);
   // a stalled pipe holds its slot, so the selector must stop refilling it
   always_comb begin
      o_int_rdy = ~i_stall[1:0];
      o_fp_rdy = ~i_stall[2];
      o_mem_rdy = ~i_stall[3];
   end
endmodule // sis_pipe_sink
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the strand issue selector
// assumes inputs change at the falling edge, outputs settle before it
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] vld = 8'h00, lls = 8'h00, lld = 8'h00, take, avail, acc;
   logic [7:0][31:0] inst;
   logic [7:0][1:0] cls = '0;
   logic [3:0] stall = 4'h0;
   logic [1:0] int_rdy, int_vld;
   logic [1:0][2:0] int_sid;
   logic [1:0][31:0] int_inst;
   logic fp_rdy, fp_vld, mem_rdy, mem_vld;
   logic [2:0] fp_sid, mem_sid;
   logic [31:0] fp_inst, mem_inst;
   int mismatches = 0;
   int checked = 0;
   // pair table: class of strand 0, class of strand 4, expected takes
   localparam logic [1:0] CA [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3};
   localparam logic [1:0] CB [9] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0};
   localparam logic [7:0] EX [9] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h01, 8'h10, 8'h01, 8'h10};

   // 25 MHz core clock
   always #20 clk = ~clk;

   sis_issue_select u_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_inst_vld(vld),
      .i_inst(inst), .i_inst_cls(cls), .o_inst_take(take), .i_lle_start(lls),
      .i_lle_done(lld), .o_strand_avail(avail), .i_int_rdy(int_rdy), .o_int_vld(int_vld),
      .o_int_sid(int_sid), .o_int_inst(int_inst), .i_fp_rdy(fp_rdy), .o_fp_vld(fp_vld),
      .o_fp_sid(fp_sid), .o_fp_inst(fp_inst), .i_mem_rdy(mem_rdy), .o_mem_vld(mem_vld),
      .o_mem_sid(mem_sid), .o_mem_inst(mem_inst));

   sis_pipe_sink u_sink (.i_stall(stall), .o_int_rdy(int_rdy),
      .o_fp_rdy(fp_rdy), .o_mem_rdy(mem_rdy));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc;
      @(posedge clk);
      @(negedge clk);
   endtask

   // every scenario starts from reset so the issue order is known
   task automatic do_reset;
      rstn = 1'b0;
      vld = 8'h00;
      lls = 8'h00;
      lld = 8'h00;
      stall = 4'h0;
      cls = '0;
      ce = 1'b1;
      for (int s = 0; s < 8; s++) inst[s] = 32'h00000a00 | s;
      repeat (16) cyc;
      rstn = 1'b1;
   endtask

   task automatic t_order;
      do_reset;
      vld = 8'hff;
      for (int k = 0; k < 8; k++) begin
         #1 chk(take, 8'h11 << (k % 4));
         cyc;
         chk(int_sid[0], k % 4);
         chk(int_sid[1], 4 + k % 4);
         chk(int_inst[0], inst[k % 4]);
         chk(int_inst[1], inst[4 + k % 4]);
      end
      // group 0 idles while group 1 runs on
      vld = 8'hf0;
      repeat (3) begin
         #1 chk(take & 8'h0f, 8'h00);
         cyc;
      end
      chk(int_vld[0], 1'b0);
      vld = 8'hff;
      #1 chk(take, 8'h81);
      $display("test order done");
   endtask

   task automatic t_event;
      do_reset;
      vld = 8'h0f;
      lls = 8'h01;
      for (int k = 0; k < 6; k++) begin
         #1 chk(take, 8'h01 << (1 + k % 3));
         cyc;
         lls = 8'h00;
         chk(avail[0], 1'b0);
      end
      lld = 8'h01;
      #1 acc = take;
      chk(acc, 8'h02);
      cyc;
      lld = 8'h00;
      chk(avail[0], 1'b1);
      #1 acc = acc | take;
      cyc;
      chk(acc[0], 1'b1);
      $display("test event done");
   endtask

   task automatic t_pairs;
      do_reset;
      vld = 8'h11;
      for (int k = 0; k < 9; k++) begin
         cls[0] = CA[k];
         cls[4] = CB[k];
         #1 chk(take, EX[k]);
         chk($countones(take) <= 2, 1'b1);
         cyc;
         if (k == 3 || k == 4) begin
            chk(fp_sid, (k == 3) ? 3'h0 : 3'h4);
            chk(mem_sid, (k == 3) ? 3'h4 : 3'h0);
            chk({fp_vld, mem_vld}, 2'h3);
            chk(fp_inst, inst[(k == 3) ? 0 : 4]);
            chk(mem_inst, inst[(k == 3) ? 4 : 0]);
         end
      end
      $display("test pairs done");
   endtask

   task automatic t_stall;
      do_reset;
      stall = 4'h1;
      vld = 8'h01;
      #1 chk(take, 8'h01);
      cyc;
      chk(int_sid[0], 3'h0);
      // a full slot refuses a second instruction
      #1 chk(take, 8'h00);
      cyc;
      chk(int_vld[0], 1'b1);
      ce = 1'b0;
      stall = 4'h0;
      #1 chk(take, 8'h00);
      cyc;
      chk(int_vld[0], 1'b1);
      ce = 1'b1;
      #1 chk(take, 8'h01);
      cyc;
      // a stalled shared fp slot refuses the next fp instruction
      cls[0] = 2'h1;
      stall = 4'h4;
      #1 chk(take, 8'h01);
      cyc;
      chk(fp_sid, 3'h0);
      #1 chk(take, 8'h00);
      cyc;
      chk(fp_vld, 1'b1);
      $display("test stall done");
   endtask

   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      @(negedge clk);
      t_order;
      t_event;
      t_pairs;
      t_stall;
      finish_test;
   end

   // the run needs well under 300 cycles; a hang costs a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      finish_test;
   end
endmodule // tb
`default_nettype wire
